// ===== rtl/trig_seq_pkg.sv
/*
 * Shared constants and types for the camera acquisition trigger sequencer:
 * register offsets, field positions, reset values, mode encodings and timing.
 * Assumes a 200 MHz camera clock and a 32-bit AXI4-Lite register bus.
 */
package trig_seq_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SYNC_STAGES   = 3;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_TRIG_CFG = 8'h04;
	localparam logic [7:0] OFS_OUT_CFG  = 8'h08;
	localparam logic [7:0] OFS_EXPOSE   = 8'h0C;
	localparam logic [7:0] OFS_SERIES   = 8'h10;
	localparam logic [7:0] OFS_SHIFT    = 8'h14;
	localparam logic [7:0] OFS_READOUT  = 8'h18;
	localparam logic [7:0] OFS_STATUS   = 8'h1C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTL_RUN_BIT    = 0;
	localparam int CTL_STOP_BIT   = 1;
	localparam int TCFG_RESP_LSB  = 0;
	localparam int TCFG_SHUT_LSB  = 4;
	localparam int TCFG_EDGE_BIT  = 8;
	localparam int OCFG_SEL1_LSB  = 0;
	localparam int OCFG_INV1_BIT  = 4;
	localparam int OCFG_SEL2_LSB  = 8;
	localparam int OCFG_INV2_BIT  = 12;

	// ----------------------------------------------------------------
	// Reset values and bus response codes
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_EXPOSE  = 32'h0000_0064;
	localparam logic [15:0] RST_SERIES  = 16'h0002;
	localparam logic [15:0] RST_SHIFT   = 16'h0010;
	localparam logic [31:0] RST_READOUT = 32'h0000_0400;
	localparam logic [1:0]  AXI_OKAY    = 2'h0;
	localparam logic [1:0]  AXI_SLVERR  = 2'h2;

	// ----------------------------------------------------------------
	// Mode encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RESP_NONE, RESP_SINGLE, RESP_READOUT, RESP_SHIFT
	} resp_mode_t;

	typedef enum logic [1:0] {
		SHUT_NORMAL, SHUT_CLOSED, SHUT_OPEN, SHUT_OPEN_BEFORE
	} shut_mode_t;

	typedef enum logic [2:0] {
		OSEL_ACQUIRING, OSEL_HIGH, OSEL_EXPOSING, OSEL_READING,
		OSEL_SHIFTING, OSEL_SHUTTER, OSEL_WAITING
	} out_sel_t;

	// Status flags shared between sequencer and output selection.
	typedef struct packed {
		logic acquiring;
		logic exposing;
		logic reading;
		logic shifting;
		logic shutter;
		logic waiting;
	} seq_status_t;

	// Configuration of one trigger output.
	typedef struct packed {
		out_sel_t sel;
		logic     inv;
	} out_cfg_t;

endpackage : trig_seq_pkg

// ===== rtl/trig_in_sync.sv
/*
 * Trigger input conditioner: three-stage synchroniser and edge detector.
 * Assumes the pin is asynchronous to mclk; an edge counts once stages two
 * and three agree on the new level.
 */
`timescale 1ns/1ps
`default_nettype none

module trig_in_sync
	import trig_seq_pkg::*;
(
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic trig_pin,
	input  wire logic fall_sel,
	output logic      edge_pulse
);

	typedef struct packed {
		logic [SYNC_STAGES-1:0] sync;
		logic                   level;
		logic                   pulse;
	} state_t;

	state_t state_reg;
	state_t state_next;

	// ----------------------------------------------------------------
	// Synchroniser and edge detection
	// ----------------------------------------------------------------

	// Stage 0 is read only by stage 1; the level updates when 1 and 2 agree.
	always_comb begin
		state_next       = state_reg;
		state_next.sync  = {state_reg.sync[SYNC_STAGES-2:0], trig_pin};
		state_next.pulse = 1'b0;
		if (state_reg.sync[1] == state_reg.sync[2] && state_reg.sync[2] != state_reg.level) begin
			state_next.level = state_reg.sync[2];
			state_next.pulse = fall_sel ? !state_reg.sync[2] : state_reg.sync[2];
		end
	end

	// Registers the conditioner state.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign edge_pulse = state_reg.pulse;

endmodule : trig_in_sync

`default_nettype wire

// ===== rtl/camera_trigger_sequencer.sv
/*
 * Acquisition trigger sequencer: AXI4-Lite registers, trigger acceptance,
 * exposure/shift/readout sequencing, shutter drive and two status outputs.
 * Assumes a single 200 MHz clock with synchronous active-low reset; cycle
 * counts for exposure, shift and readout are programmed by software.
 */
`timescale 1ns/1ps
`default_nettype none

module camera_trigger_sequencer
	import trig_seq_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        trig_in,
	output logic             shutter_open,
	output logic             trig_out1,
	output logic             trig_out2
);

	typedef enum logic [2:0] {
		ST_IDLE, ST_OPENING, ST_WAIT_TRIG, ST_EXPOSE, ST_SHIFT, ST_READOUT
	} seq_state_t;

	typedef struct packed {
		// Bus side.
		logic        aw_taken;
		logic [7:0]  aw_addr;
		logic        w_taken;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		// Configuration.
		logic [31:0] trig_cfg;
		logic [31:0] out_cfg;
		logic [31:0] expose_cycles;
		logic [15:0] series_len;
		logic [15:0] shift_cycles;
		logic [31:0] readout_cycles;
		// Sequencer.
		seq_state_t  seq;
		logic        run;
		logic [31:0] count;
		logic [15:0] done_frames;
		logic [15:0] ignored;
		logic        shutter;
		logic        out1;
		logic        out2;
	} state_t;

	state_t      state_reg;
	state_t      state_next;
	logic        trig_edge;
	seq_status_t stat;
	resp_mode_t  resp;
	shut_mode_t  shut;
	logic        busy;

	// ----------------------------------------------------------------
	// Trigger input conditioning
	// ----------------------------------------------------------------

	// Synchronises the pin and reports edges of the selected polarity.
	trig_in_sync u_sync (
		.mclk       (mclk),
		.nrst       (nrst),
		.trig_pin   (trig_in),
		.fall_sel   (state_reg.trig_cfg[TCFG_EDGE_BIT]),
		.edge_pulse (trig_edge)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Merges write data into a register under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = din[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// Picks a status source for one trigger output and applies its inversion.
	function automatic logic out_level(input out_cfg_t cfg, input seq_status_t st);
		logic lvl;
		lvl = 1'b0;
		unique case (cfg.sel)
			OSEL_ACQUIRING: lvl = st.acquiring;
			OSEL_HIGH:      lvl = 1'b1;
			OSEL_EXPOSING:  lvl = st.exposing;
			OSEL_READING:   lvl = st.reading;
			OSEL_SHIFTING:  lvl = st.shifting;
			OSEL_SHUTTER:   lvl = st.shutter;
			OSEL_WAITING:   lvl = st.waiting;
			default:        lvl = 1'b0;
		endcase
		return lvl ^ cfg.inv;
	endfunction : out_level

	// ----------------------------------------------------------------
	// Decoded configuration and status
	// ----------------------------------------------------------------

	// Mode fields and live status flags derived from the registered state.
	always_comb begin
		resp           = resp_mode_t'(state_reg.trig_cfg[TCFG_RESP_LSB +: 2]);
		shut           = shut_mode_t'(state_reg.trig_cfg[TCFG_SHUT_LSB +: 2]);
		stat.acquiring = state_reg.seq != ST_IDLE;
		stat.exposing  = state_reg.seq == ST_EXPOSE;
		stat.reading   = state_reg.seq == ST_READOUT;
		stat.shifting  = state_reg.seq == ST_SHIFT;
		stat.shutter   = state_reg.shutter;
		stat.waiting   = state_reg.seq == ST_WAIT_TRIG;
		busy           = state_reg.seq inside {ST_EXPOSE, ST_SHIFT, ST_READOUT};
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------

	// Bus slave, register writes and the acquisition sequencer.
	always_comb begin
		logic accept;
		logic last;
		state_next = state_reg;
		accept     = 1'b0;
		last       = 1'b0;

		// Write address and data are taken in either order, then answered.
		if (s_axi_awvalid && !state_reg.aw_taken && !state_reg.bvalid) begin
			state_next.aw_taken = 1'b1;
			state_next.aw_addr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_reg.w_taken && !state_reg.bvalid) begin
			state_next.w_taken = 1'b1;
			state_next.w_data  = s_axi_wdata;
			state_next.w_strb  = s_axi_wstrb;
		end
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end
		if (state_reg.aw_taken && state_reg.w_taken) begin
			state_next.aw_taken = 1'b0;
			state_next.w_taken  = 1'b0;
			state_next.bvalid   = 1'b1;
			state_next.bresp    = AXI_OKAY;
			unique case (state_reg.aw_addr[7:2])
				OFS_CONTROL[7:2]: begin
					if (state_reg.w_strb[0] && state_reg.w_data[CTL_RUN_BIT]) begin
						state_next.run = 1'b1;
					end
					if (state_reg.w_strb[0] && state_reg.w_data[CTL_STOP_BIT]) begin
						state_next.run = 1'b0;
					end
				end
				OFS_TRIG_CFG[7:2]: state_next.trig_cfg = merge(state_reg.trig_cfg, state_reg.w_data,
					state_reg.w_strb);
				OFS_OUT_CFG[7:2]:  state_next.out_cfg = merge(state_reg.out_cfg, state_reg.w_data,
					state_reg.w_strb);
				OFS_EXPOSE[7:2]:   state_next.expose_cycles = merge(state_reg.expose_cycles,
					state_reg.w_data, state_reg.w_strb);
				OFS_SERIES[7:2]:   state_next.series_len = 16'(merge({16'h0000, state_reg.series_len},
					state_reg.w_data, state_reg.w_strb));
				OFS_SHIFT[7:2]:    state_next.shift_cycles = 16'(merge({16'h0000, state_reg.shift_cycles},
					state_reg.w_data, state_reg.w_strb));
				OFS_READOUT[7:2]:  state_next.readout_cycles = merge(state_reg.readout_cycles,
					state_reg.w_data, state_reg.w_strb);
				OFS_STATUS[7:2]:   state_next.bresp = AXI_OKAY;
				default:           state_next.bresp = AXI_SLVERR;
			endcase
		end

		// Reads are answered one cycle after the address is taken.
		if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !state_reg.rvalid) begin
			state_next.rvalid = 1'b1;
			state_next.rresp  = AXI_OKAY;
			unique case (s_axi_araddr[7:2])
				OFS_CONTROL[7:2]:  state_next.rdata = {31'h0000_0000, state_reg.run};
				OFS_TRIG_CFG[7:2]: state_next.rdata = state_reg.trig_cfg;
				OFS_OUT_CFG[7:2]:  state_next.rdata = state_reg.out_cfg;
				OFS_EXPOSE[7:2]:   state_next.rdata = state_reg.expose_cycles;
				OFS_SERIES[7:2]:   state_next.rdata = {16'h0000, state_reg.series_len};
				OFS_SHIFT[7:2]:    state_next.rdata = {16'h0000, state_reg.shift_cycles};
				OFS_READOUT[7:2]:  state_next.rdata = state_reg.readout_cycles;
				OFS_STATUS[7:2]:   state_next.rdata = {state_reg.ignored, state_reg.done_frames[7:0],
					2'h0, stat};
				default: begin
					state_next.rdata = 32'h0000_0000;
					state_next.rresp = AXI_SLVERR;
				end
			endcase
		end

		// Triggers during exposure, shift or readout are dropped, and counted unless the response mode is RESP_NONE.
		if (trig_edge && busy && resp != RESP_NONE) begin
			state_next.ignored = state_reg.ignored + 16'h0001;
		end
		accept = trig_edge && state_reg.seq == ST_WAIT_TRIG;
		last   = state_reg.done_frames + 16'h0001 >= state_reg.series_len;

		// Acquisition sequencer.
		unique case (state_reg.seq)
			ST_IDLE: begin
				state_next.count = 32'h0000_0000;
				state_next.done_frames = 16'h0000;
				if (state_reg.run) begin
					state_next.seq = (resp == RESP_NONE) ? ST_EXPOSE : ST_OPENING;
				end
			end
			ST_OPENING: begin
				state_next.seq = ST_WAIT_TRIG;
			end
			ST_WAIT_TRIG: begin
				if (!state_reg.run) begin
					state_next.seq = ST_IDLE;
				end else if (accept) begin
					state_next.seq   = ST_EXPOSE;
					state_next.count = 32'h0000_0000;
				end
			end
			ST_EXPOSE: begin
				state_next.count = state_reg.count + 32'h0000_0001;
				// Shift-per-trigger exposure lasts one cycle; expose_cycles is not used.
				if (resp == RESP_SHIFT || state_reg.count + 32'h0000_0001 >= state_reg.expose_cycles) begin
					state_next.seq   = ST_SHIFT;
					state_next.count = 32'h0000_0000;
				end
			end
			ST_SHIFT: begin
				state_next.count = state_reg.count + 32'h0000_0001;
				if ({16'h0000, state_reg.count[15:0]} + 32'h0000_0001 >= {16'h0000, state_reg.shift_cycles}) begin
					state_next.count       = 32'h0000_0000;
					state_next.done_frames = state_reg.done_frames + 16'h0001;
					if (last) begin
						state_next.seq = ST_READOUT;
					end else if (resp == RESP_SHIFT) begin
						state_next.seq = ST_WAIT_TRIG;
					end else begin
						state_next.seq = ST_EXPOSE;
					end
				end
			end
			ST_READOUT: begin
				state_next.count = state_reg.count + 32'h0000_0001;
				if (state_reg.count + 32'h0000_0001 >= state_reg.readout_cycles) begin
					state_next.done_frames = 16'h0000;
					state_next.count       = 32'h0000_0000;
					// Rearm for the next series while run stays set.
					state_next.seq = !state_reg.run ? ST_IDLE :
						(resp == RESP_NONE) ? ST_EXPOSE : ST_OPENING;
				end
			end
			default: state_next.seq = ST_IDLE;
		endcase

		// Shutter drive for the four shutter modes.
		unique case (shut)
			SHUT_CLOSED: state_next.shutter = 1'b0;
			SHUT_OPEN:   state_next.shutter = 1'b1;
			SHUT_OPEN_BEFORE:
				state_next.shutter = state_next.seq inside {ST_OPENING, ST_WAIT_TRIG, ST_EXPOSE, ST_SHIFT};
			default: begin
				// Normal opens when armed in readout or shift per trigger (else only while exposing) and
				// stays open through the series in shift-per-trigger mode.
				state_next.shutter = (resp == RESP_SHIFT || resp == RESP_READOUT) ?
					state_next.seq inside {ST_OPENING, ST_WAIT_TRIG, ST_EXPOSE, ST_SHIFT} :
					state_next.seq == ST_EXPOSE;
			end
		endcase

		state_next.out1 = out_level(out_cfg_t'({state_reg.out_cfg[OCFG_SEL1_LSB +: 3],
			state_reg.out_cfg[OCFG_INV1_BIT]}), stat);
		state_next.out2 = out_level(out_cfg_t'({state_reg.out_cfg[OCFG_SEL2_LSB +: 3],
			state_reg.out_cfg[OCFG_INV2_BIT]}), stat);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Registers all state; reset loads constants only.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_reg                <= '0;
			state_reg.seq            <= ST_IDLE;
			state_reg.expose_cycles  <= RST_EXPOSE;
			state_reg.series_len     <= RST_SERIES;
			state_reg.shift_cycles   <= RST_SHIFT;
			state_reg.readout_cycles <= RST_READOUT;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs come straight from the state register.
	assign s_axi_awready = !state_reg.aw_taken && !state_reg.bvalid;
	assign s_axi_wready  = !state_reg.w_taken && !state_reg.bvalid;
	assign s_axi_bvalid  = state_reg.bvalid;
	assign s_axi_bresp   = state_reg.bresp;
	assign s_axi_arready = !state_reg.rvalid;
	assign s_axi_rvalid  = state_reg.rvalid;
	assign s_axi_rdata   = state_reg.rdata;
	assign s_axi_rresp   = state_reg.rresp;
	assign shutter_open  = state_reg.shutter;
	assign trig_out1     = state_reg.out1;
	assign trig_out2     = state_reg.out2;

endmodule : camera_trigger_sequencer

`default_nettype wire

// ===== verif/trig_src_model.sv
/* Trigger source model: drives the trigger pin in whole cycles.
   Assumes the pin idles low. */
`timescale 1ns/1ps
`default_nettype none
module trig_src_model (
	input  wire logic mclk,
	output logic      trig_pin
);
	// The pin idles low, so the first pulse rises cleanly.
	initial trig_pin = 1'b0;

	// Sets the pin after an edge and holds it n cycles.
	task automatic drive(input logic v, input int n);
		@(posedge mclk);
		trig_pin <= v;
		repeat (n) @(posedge mclk);
	endtask : drive
endmodule : trig_src_model
`default_nettype wire

// ===== verif/camera_trigger_sequencer_checker.sv
/* Checker: bus handshakes, reset levels, output selection.
   Assumes address and data are offered together. */
`timescale 1ns/1ps
`default_nettype none
module camera_trigger_sequencer_checker
	import trig_seq_pkg::*;
(
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        shutter_open,
	input wire logic        trig_out1,
	input wire logic        trig_out2
);
	logic [31:0] ocfg_reg;
	logic [31:0] tcfg_reg;
	logic [3:0]  age_reg;
	wire logic   wr_hs   = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire logic   settled = age_reg > 4'h4;

	// Configuration copies and cycles since the last write.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ocfg_reg <= 32'h0000_0000;
			tcfg_reg <= 32'h0000_0000;
			age_reg  <= 4'h0;
		end else begin
			if (wr_hs && s_axi_awaddr == OFS_OUT_CFG) ocfg_reg <= s_axi_wdata;
			if (wr_hs && s_axi_awaddr == OFS_TRIG_CFG) tcfg_reg <= s_axi_wdata;
			age_reg <= wr_hs ? 4'h0 : (age_reg == 4'hF ? age_reg : age_reg + 4'h1);
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	// A write is both items taken, then the response within two cycles.
	sequence wr_taken;
		wr_hs;
	endsequence
	sequence wr_answered;
		##[1:2] s_axi_bvalid;
	endsequence

	a_wr_answer: assert property (wr_taken |-> wr_answered)
		else $error("write response late");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("response not cleared");
	a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_reset_outs: assert property (@(posedge mclk) disable iff (1'b0)
		!nrst |=> !shutter_open && !trig_out1 && !trig_out2 && s_axi_awready && s_axi_arready)
		else $error("outputs wrong after reset");
	a_high_out: assert property (settled && ocfg_reg[2:0] == 3'h1 |-> trig_out1 == !ocfg_reg[4])
		else $error("always-high output wrong");
	a_inv_pair: assert property (settled && ocfg_reg[2:0] == ocfg_reg[10:8] && ocfg_reg[4] != ocfg_reg[12]
		|-> trig_out1 != trig_out2)
		else $error("inverted output pair equal");
	a_same_pair: assert property (settled && ocfg_reg[2:0] == ocfg_reg[10:8] && ocfg_reg[4] == ocfg_reg[12]
		|-> trig_out1 == trig_out2)
		else $error("matching outputs differ");
	a_shut_closed: assert property (settled && tcfg_reg[5:4] == 2'h1 |-> !shutter_open)
		else $error("shutter open in closed mode");
endmodule : camera_trigger_sequencer_checker

bind camera_trigger_sequencer camera_trigger_sequencer_checker u_camera_trigger_sequencer_checker (
	.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.shutter_open, .trig_out1, .trig_out2);
`default_nettype wire

// ===== verif/camera_trigger_sequencer_tb_top.sv
/* Testbench: bus tasks, trigger source, mode scenarios.
   Assumes the package is compiled first. */
`timescale 1ns/1ps
`default_nettype none
module camera_trigger_sequencer_tb_top import trig_seq_pkg::*;;
	logic        mclk = 1'b0, nrst = 1'b0, to1_q = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, trig_in, shutter_open, to1, to2;
	logic [1:0]  bresp, rresp, r;
	int          failures = 0, tests_run = 0, ecnt = 0, e0, m;
	logic [7:0]  adr [4] = '{OFS_EXPOSE, OFS_SERIES, OFS_SHIFT, OFS_READOUT};
	logic [31:0] rv [4]  = '{RST_EXPOSE, 32'(RST_SERIES), 32'(RST_SHIFT), RST_READOUT};

	// The 200 MHz clock.
	always #2.5 mclk = ~mclk;

	// Counts rising edges of the first output (exposures).
	always @(posedge mclk) begin
		to1_q <= to1;
		if (to1 && !to1_q) ecnt <= ecnt + 1;
	end

	camera_trigger_sequencer u_camera_trigger_sequencer (.mclk(mclk), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .trig_in(trig_in), .shutter_open(shutter_open), .trig_out1(to1), .trig_out2(to2));
	trig_src_model u_trig_src_model (.mclk(mclk), .trig_pin(trig_in));

	// ----------------------------------------------------------------
	// Bus and comparison tasks
	// ----------------------------------------------------------------
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n = 0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (!(bvalid && bready) && n < 200);
		r = bresp;
		bready <= 1'b0;
		check("write done", n < 200, 1);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n = 0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (!(rvalid && rready) && n < 200);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	// Waits, bounded, for a level on the second output.
	task automatic wait_to2(input logic v);
		int n = 0;
		while (to2 !== v && n < 500) begin
			@(posedge mclk);
			n++;
		end
		check("level reached", n < 500, 1);
	endtask : wait_to2

	function automatic logic [31:0] tcfg(input logic [1:0] rs, input logic [1:0] sh, input logic fe);
		return {23'h0, fe, 2'h0, sh, 2'h0, rs};
	endfunction : tcfg

	function automatic logic [31:0] ocfg(input logic [2:0] s1, input logic i1, input logic [2:0] s2, input logic i2);
		return {19'h0, i2, 1'h0, s2, 3'h0, i1, 1'h0, s1};
	endfunction : ocfg

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	// Ends a hung run.
	initial begin
		repeat (8000) @(posedge mclk);
		failures++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		foreach (adr[i]) begin
			rd(adr[i]);
			check("reset value", d, rv[i]);
		end
		rd(8'h20);
		check("unmapped read", r, AXI_SLVERR);
		wr(8'h20, 32'h0);
		check("unmapped write", r, AXI_SLVERR);
		wr(OFS_EXPOSE, 32'h4);
		wr(OFS_SHIFT, 32'h3);
		wr(OFS_READOUT, 32'h28);
		$display("test registers done");
		wr(OFS_OUT_CFG, ocfg(OSEL_HIGH, 1'b0, OSEL_HIGH, 1'b1));
		repeat (4) @(posedge mclk);
		check("high output", to1, 1);
		check("inverted high", to2, 0);
		wr(OFS_OUT_CFG, ocfg(OSEL_ACQUIRING, 1'b0, OSEL_WAITING, 1'b0));
		wr(OFS_TRIG_CFG, tcfg(2'h2, 2'h0, 1'b0));
		check("idle acquiring", to1, 0);
		wr(OFS_CONTROL, 32'h1);
		repeat (6) @(posedge mclk);
		check("armed acquiring", to1, 1);
		check("armed waiting", to2, 1);
		wr(OFS_CONTROL, 32'h2);
		$display("test outputs done");
		wr(OFS_OUT_CFG, ocfg(OSEL_EXPOSING, 1'b0, OSEL_READING, 1'b0));
		for (m = 0; m < 4; m++) begin
			wr(OFS_TRIG_CFG, tcfg(2'h2, m[1:0], 1'b0));
			wr(OFS_CONTROL, 32'h1);
			repeat (6) @(posedge mclk);
			rd(OFS_STATUS);
			check("waiting after arm", d[0], 1);
			check("shutter at arm", shutter_open, m != 1);
			e0 = ecnt;
			u_trig_src_model.drive(1'b1, 10);
			u_trig_src_model.drive(1'b0, 1);
			wait_to2(1'b1);
			check("series exposures", ecnt - e0, 2);
			if (m == 0 || m == 3) check("shutter in readout", shutter_open, 0);
			u_trig_src_model.drive(1'b1, 8);
			u_trig_src_model.drive(1'b0, 1);
			wait_to2(1'b0);
			repeat (8) @(posedge mclk);
			rd(OFS_STATUS);
			check("ready again", d[0], 1);
			check("dropped triggers", d[31:16], m + 1);
			check("nothing queued", ecnt - e0, 2);
			wr(OFS_CONTROL, 32'h2);
		end
		$display("test readout per trigger done");
		wr(OFS_OUT_CFG, ocfg(OSEL_EXPOSING, 1'b0, OSEL_SHIFTING, 1'b1));
		wr(OFS_TRIG_CFG, tcfg(2'h3, 2'h3, 1'b1));
		wr(OFS_CONTROL, 32'h1);
		e0 = ecnt;
		for (m = 0; m < 2; m++) begin
			u_trig_src_model.drive(1'b1, 12);
			check("rising edge ignored", ecnt - e0, m);
			u_trig_src_model.drive(1'b0, 14);
			check("one cycle per trigger", ecnt - e0, m + 1);
			check("inverted shifting", to2, 1);
			check("shutter over series", shutter_open, m == 0);
		end
		repeat (50) @(posedge mclk);
		rd(OFS_STATUS);
		check("rearmed", d[0], 1);
		wr(OFS_CONTROL, 32'h2);
		$display("test shift per trigger done");
		wr(OFS_TRIG_CFG, tcfg(2'h0, 2'h1, 1'b0));
		wr(OFS_CONTROL, 32'h1);
		e0 = ecnt;
		u_trig_src_model.drive(1'b1, 40);
		u_trig_src_model.drive(1'b0, 40);
		check("free running frames", ecnt - e0 > 1, 1);
		check("closed shutter", shutter_open, 0);
		wr(OFS_CONTROL, 32'h2);
		$display("test no response done");
		give_verdict();
	end
endmodule : camera_trigger_sequencer_tb_top
`default_nettype wire
